// ---- shared/misc_feature_consts.svh ----
// constants for the miscellaneous feature-enable register slice and its bus map
`ifndef MISC_FEATURE_CONSTS_SVH
`define MISC_FEATURE_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// bus map (byte addresses)
`define OFS_FEAT_LO 12'h000
`define OFS_FEAT_HI 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C

////////////////////////////////////////////////////////////////////////////////
// feature word fields
`define BIT_FP_REPORT 10
`define BIT_TRACE_ABSENT 11
`define BIT_SAMPLING_ABSENT 12
`define BIT_PREFETCH_DIS 19
`define FEAT_LO_WMASK 32'h0008_0400
`define FEAT_LO_RESET 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// interrupt status fields
`define STATUS_W 2
`define ST_WAKE 0
`define ST_FPERR 1
`define STATUS_RESET 2'h0

////////////////////////////////////////////////////////////////////////////////
// fetch geometry
`define FETCH_ADDR_W 32
`define SECTOR_BYTES 128
`define LINE_BYTES 64

`endif

// ---- shared/misc_feature_pkg.sv ----
// types shared by the feature-enable register slice and its helpers
`include "misc_feature_consts.svh"

package misc_feature_pkg;

	typedef struct packed {
		logic fpReportEn;
		logic prefetchDisable;
	} feature_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [`FETCH_ADDR_W-1:0] addr;
	} fetch_line_t;

endpackage : misc_feature_pkg

// ---- src/fp_error_pin_ctrl.sv ----
// floating-point-error pin driver and stop-clock wake sensing
`timescale 1ns/1ps
`include "misc_feature_consts.svh"

module fp_error_pin_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	input misc_feature_pkg::feature_ctrl_t ctrl,
	input wire logic stopClockInputN,
	input wire logic fpErrorPinInN,
	input wire logic fpUnmaskedErr,
	output logic fpErrorPinOutN_q,
	output logic fpErrorPinOe_q,
	output logic wakeReq_q,
	output logic wakeEvent_q,
	output logic fpErrEvent_q
);

	wire stopped = !stopClockInputN;
	// only flag errors outside stop-clock, independent of the enable
	wire driveErr = fpUnmaskedErr && !stopped;
	// own drive is masked out so a late release is not mistaken for a wake
	wire wakeCond = ctrl.fpReportEn && stopped && !fpErrorPinInN && !fpErrorPinOe_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fpErrorPinOutN_q <= 1'b1;
			fpErrorPinOe_q <= 1'b0;
			wakeReq_q <= 1'b0;
			wakeEvent_q <= 1'b0;
			fpErrEvent_q <= 1'b0;
		end else begin
			fpErrorPinOutN_q <= 1'b0;
			fpErrorPinOe_q <= driveErr;
			wakeReq_q <= wakeCond;
			wakeEvent_q <= wakeCond && !wakeReq_q;
			fpErrEvent_q <= driveErr && !fpErrorPinOe_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	wake_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wakeReq_q |-> $past(ctrl.fpReportEn) && !$past(stopClockInputN) && !$past(fpErrorPinInN))
		else $error("wake request without enabled stop-clock pin assertion");
	wake_disabled_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!ctrl.fpReportEn ##1 !ctrl.fpReportEn |-> !wakeReq_q)
		else $error("wake request while pin reporting is off");
	err_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fpUnmaskedErr && stopClockInputN |=> fpErrorPinOe_q && !fpErrorPinOutN_q)
		else $error("unmasked error not flagged on the pin");

endmodule : fp_error_pin_ctrl

// ---- src/misc_feature_ctrl.sv ----
// feature-enable register slice (bits 10..19) behind an apb slave, with wake and prefetch logic
//
// Summary of operation
// - bit 10 writable; set enables wake reporting via the error pin, clear disables it
// - enabled and stop-clock asserted: error pin assertion requests return to normal operation
// - outside stop-clock the pin flags unmasked fp errors regardless of bit 10
// - bit 11 read-only, one when branch trace storage is absent
// - bit 12 read-only, one when precise event sampling is absent
// - bit 19 set: fetch only the line holding the required data
// - bit 19 clear: fetch both lines of the 128-byte sector
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "misc_feature_consts.svh"

module misc_feature_ctrl #(
	parameter int APB_ADDR_W = 12,
	parameter bit TRACE_STORE_SUPPORTED = 1'b1,
	parameter bit PRECISE_SAMPLING_SUPPORTED = 1'b1,
	parameter int SECTOR_BYTES = `SECTOR_BYTES,
	parameter int LINE_BYTES = `LINE_BYTES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic stopClockInputN,
	input wire logic fpErrorPinInN,
	input wire logic fpUnmaskedErr,
	output logic fpErrorPinOutN,
	output logic fpErrorPinOe,
	output logic wakeReq,
	input misc_feature_pkg::fetch_line_t fetchReq,
	output misc_feature_pkg::fetch_line_t fetchLine,
	output misc_feature_pkg::fetch_line_t fetchPair
);

	// refused at elaboration: the map needs four address bits and apb allows no more than 32
	if (APB_ADDR_W < 4 || APB_ADDR_W > 32) begin : g_bad_addr_w
		$error("apb address width must lie between 4 and 32");
	end
	if (SECTOR_BYTES != 2 * LINE_BYTES) begin : g_bad_sector
		$error("sector must hold exactly two lines");
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	localparam logic [APB_ADDR_W-1:0] A_LO = APB_ADDR_W'(`OFS_FEAT_LO);
	localparam logic [APB_ADDR_W-1:0] A_HI = APB_ADDR_W'(`OFS_FEAT_HI);
	localparam logic [APB_ADDR_W-1:0] A_ST = APB_ADDR_W'(`OFS_IRQ_STATUS);
	localparam logic [APB_ADDR_W-1:0] A_MK = APB_ADDR_W'(`OFS_IRQ_MASK);

	logic [31:0] featLo_q;
	logic [31:0] featLo_d;
	logic [`STATUS_W-1:0] status_q;
	logic [`STATUS_W-1:0] status_d;
	logic [`STATUS_W-1:0] mask_q;
	logic [`STATUS_W-1:0] mask_d;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	wire setupPhase = psel && !penable;
	wire accessDone = psel && penable && pready_q;
	wire hitLo = paddr == A_LO;
	wire hitHi = paddr == A_HI;
	wire hitSt = paddr == A_ST;
	wire hitMk = paddr == A_MK;
	wire mapped = hitLo || hitHi || hitSt || hitMk;
	wire wrDone = accessDone && pwrite && mapped;

	// byte lanes expanded to a bit mask
	wire [31:0] laneMask;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign laneMask[gi*8 +: 8] = {8{pstrb[gi]}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// feature word

	// capability flags are wired, never stored
	wire traceAbsent = !TRACE_STORE_SUPPORTED;
	wire samplingAbsent = !PRECISE_SAMPLING_SUPPORTED;
	wire [31:0] wMask = `FEAT_LO_WMASK & laneMask;
	assign featLo_d = (wrDone && hitLo) ? ((featLo_q & ~wMask) | (pwdata & wMask)) : featLo_q;

	misc_feature_pkg::feature_ctrl_t ctrl;
	assign ctrl = '{fpReportEn: featLo_q[`BIT_FP_REPORT],
		prefetchDisable: featLo_q[`BIT_PREFETCH_DIS]};

	wire [31:0] featLoRead = featLo_q
		| (32'(traceAbsent) << `BIT_TRACE_ABSENT)
		| (32'(samplingAbsent) << `BIT_SAMPLING_ABSENT);

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	logic wakeEvent;
	logic fpErrEvent;
	wire [`STATUS_W-1:0] events = {fpErrEvent, wakeEvent};
	wire [`STATUS_W-1:0] w1c = (wrDone && hitSt && pstrb[0]) ? pwdata[`STATUS_W-1:0] : '0;
	// a new event in the clearing cycle survives the clear
	assign status_d = (status_q & ~w1c) | events;
	assign mask_d = (wrDone && hitMk && pstrb[0]) ? pwdata[`STATUS_W-1:0] : mask_q;

	wire [31:0] readMux = hitLo ? featLoRead
		: hitSt ? 32'(status_q)
		: hitMk ? 32'(mask_q)
		: 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			featLo_q <= `FEAT_LO_RESET;
			status_q <= `STATUS_RESET;
			mask_q <= `STATUS_RESET;
			irq_q <= 1'b0;
		end else begin
			featLo_q <= featLo_d;
			status_q <= status_d;
			mask_q <= mask_d;
			irq_q <= |(status_q & mask_q);
		end
	end

	// one wait-free access: read data are sampled in the setup cycle, write data in the access cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setupPhase;
			pslverr_q <= setupPhase && !mapped;
			prdata_q <= (setupPhase && !pwrite) ? readMux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// pin and fetch helpers

	fp_error_pin_ctrl u_pin (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.ctrl(ctrl),
		.stopClockInputN(stopClockInputN),
		.fpErrorPinInN(fpErrorPinInN),
		.fpUnmaskedErr(fpUnmaskedErr),
		.fpErrorPinOutN_q(fpErrorPinOutN),
		.fpErrorPinOe_q(fpErrorPinOe),
		.wakeReq_q(wakeReq),
		.wakeEvent_q(wakeEvent),
		.fpErrEvent_q(fpErrEvent)
	);

	sector_fetch_planner #(
		.SECTOR_BYTES(SECTOR_BYTES),
		.LINE_BYTES(LINE_BYTES)
	) u_fetch (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.prefetchDisable(ctrl.prefetchDisable),
		.fetchReq(fetchReq),
		.fetchLine_q(fetchLine),
		.fetchPair_q(fetchPair)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	// helpers that name the bus events the checks refer to
	wire clrWake = wrDone && hitSt && pstrb[0] && pwdata[`ST_WAKE];
	wire clrErr = wrDone && hitSt && pstrb[0] && pwdata[`ST_FPERR];
	wire rdSetup = setupPhase && !pwrite;
	wire loWrite = wrDone && hitLo;

	fp_enable_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrDone && hitLo && pstrb[1] |=> ctrl.fpReportEn == $past(pwdata[`BIT_FP_REPORT]))
		else $error("pin reporting enable did not take the written value");
	prefetch_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrDone && hitLo && pstrb[2] |=> ctrl.prefetchDisable == $past(pwdata[`BIT_PREFETCH_DIS]))
		else $error("prefetch disable did not take the written value");
	cap_flags_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		setupPhase && !pwrite && hitLo |=> prdata_q[`BIT_TRACE_ABSENT] == !TRACE_STORE_SUPPORTED
		&& prdata_q[`BIT_SAMPLING_ABSENT] == !PRECISE_SAMPLING_SUPPORTED)
		else $error("capability flags read wrong");
	reserved_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		setupPhase && !pwrite && hitLo |=> (prdata_q & 32'hFFF7_E3FF) == 32'h0000_0000)
		else $error("reserved feature bits read non-zero");
	cap_unwritable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(featLo_q & ~`FEAT_LO_WMASK) == 32'h0000_0000)
		else $error("non-writable feature bit stored");
	apb_ready_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		setupPhase |=> pready_q ##1 !pready_q || (psel && !penable))
		else $error("apb answer not one cycle after setup");
	sticky_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wakeEvent |=> status_q[`ST_WAKE])
		else $error("wake event lost against clear");
	irq_level_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		|(status_q & mask_q) |=> irq_q)
		else $error("interrupt not raised for unmasked status");

	// bus protocol
	unmapped_err_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		setupPhase && !mapped |=> pready_q && pslverr_q && prdata_q == 32'h0000_0000)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		setupPhase && mapped |=> !pslverr_q)
		else $error("error answer for a mapped register");
	err_with_ready_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		pslverr_q |-> pready_q)
		else $error("error answer without ready");
	ready_single_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		pready_q |=> !pready_q)
		else $error("ready held longer than one cycle");
	idle_rdata_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pready_q |-> prdata_q == 32'h0000_0000)
		else $error("read data shown outside the access cycle");
	unmapped_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		accessDone && pwrite && !mapped |=> featLo_q == $past(featLo_q) && mask_q == $past(mask_q))
		else $error("write to an unmapped address landed");

	// feature word and fetch routing
	hi_read_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rdSetup && hitHi |=> prdata_q == 32'h0000_0000)
		else $error("upper feature word reads non-zero");
	hi_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		accessDone && pwrite && hitHi |=> featLo_q == $past(featLo_q))
		else $error("upper feature word write changed the lower word");
	fp_enable_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!loWrite |=> $stable(ctrl.fpReportEn))
		else $error("pin reporting enable changed without a write");
	prefetch_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!loWrite |=> $stable(ctrl.prefetchDisable))
		else $error("prefetch disable changed without a write");
	lane_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		loWrite && !pstrb[1] |=> $stable(ctrl.fpReportEn))
		else $error("pin reporting enable written through a disabled lane");
	route_single_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetchReq.valid && ctrl.prefetchDisable |=> fetchLine.valid && !fetchPair.valid)
		else $error("pair fetch issued while prefetch disabled");
	route_pair_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetchReq.valid && !ctrl.prefetchDisable |=> fetchLine.valid && fetchPair.valid)
		else $error("pair fetch missing while prefetch enabled");

	// pin events
	pin_quiet_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!stopClockInputN |=> !fpErrorPinOe)
		else $error("pin driven during stop-clock");
	err_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fpUnmaskedErr && stopClockInputN && !fpErrorPinOe |=> fpErrEvent)
		else $error("error flag event missing");
	wake_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		ctrl.fpReportEn && !stopClockInputN && !fpErrorPinInN && !fpErrorPinOe && !wakeReq |=> wakeEvent)
		else $error("wake event missing");

	// status and mask
	err_sticky_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fpErrEvent |=> status_q[`ST_FPERR])
		else $error("error event lost against clear");
	wake_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		status_q[`ST_WAKE] && !clrWake |=> status_q[`ST_WAKE])
		else $error("wake status dropped without a clear");
	wake_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clrWake && !wakeEvent |=> !status_q[`ST_WAKE])
		else $error("wake status not cleared");
	err_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		status_q[`ST_FPERR] && !clrErr |=> status_q[`ST_FPERR])
		else $error("error status dropped without a clear");
	err_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clrErr && !fpErrEvent |=> !status_q[`ST_FPERR])
		else $error("error status not cleared");
	mask_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrDone && hitMk && pstrb[0] |=> mask_q == $past(pwdata[`STATUS_W-1:0]))
		else $error("mask did not take the written value");
	status_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rdSetup && hitSt |=> prdata_q == 32'($past(status_q)))
		else $error("status read wrong");
	irq_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!(|(status_q & mask_q)) |=> !irq_q)
		else $error("interrupt raised without unmasked status");

endmodule : misc_feature_ctrl

// ---- src/sector_fetch_planner.sv ----
// turns a data request into one or two line fetches within its sector
`timescale 1ns/1ps
`include "misc_feature_consts.svh"

module sector_fetch_planner #(
	parameter int SECTOR_BYTES = `SECTOR_BYTES,
	parameter int LINE_BYTES = `LINE_BYTES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic prefetchDisable,
	input misc_feature_pkg::fetch_line_t fetchReq,
	output misc_feature_pkg::fetch_line_t fetchLine_q,
	output misc_feature_pkg::fetch_line_t fetchPair_q
);

	// refused at elaboration: the pair address is a single bit flip of the line address
	if (SECTOR_BYTES != 2 * LINE_BYTES || LINE_BYTES < 2
		|| (LINE_BYTES & (LINE_BYTES - 1)) != 0) begin : g_bad_geom
		$error("sector must hold exactly two power-of-two lines");
	end

	localparam logic [`FETCH_ADDR_W-1:0] LINE_SZ = `FETCH_ADDR_W'(LINE_BYTES);
	wire [`FETCH_ADDR_W-1:0] lineAddr = fetchReq.addr & ~(LINE_SZ - `FETCH_ADDR_W'(1));
	wire [`FETCH_ADDR_W-1:0] pairAddr = lineAddr ^ LINE_SZ;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fetchLine_q <= '0;
			fetchPair_q <= '0;
		end else begin
			fetchLine_q <= '{valid: fetchReq.valid, addr: lineAddr};
			fetchPair_q <= '{valid: fetchReq.valid && !prefetchDisable, addr: pairAddr};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	single_line_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetchReq.valid && prefetchDisable |=> fetchLine_q.valid && !fetchPair_q.valid)
		else $error("adjacent line fetched while prefetch disabled");
	both_lines_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetchReq.valid && !prefetchDisable |=> fetchPair_q.valid
		&& (fetchPair_q.addr ^ fetchLine_q.addr) == LINE_SZ)
		else $error("sector pair not fetched");

endmodule : sector_fetch_planner

// ---- test/misc_feature_ctrl_tb_top.sv ----
// self-checking bench for the feature-enable register slice
`timescale 1ns/1ps
`include "misc_feature_consts.svh"

module misc_feature_ctrl_tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic stopClockInputN = 1'b1;
	logic fpErrorPinInN = 1'b1;
	logic fpUnmaskedErr = 1'b0;
	logic fpErrorPinOutN;
	logic fpErrorPinOe;
	logic wakeReq;
	misc_feature_pkg::fetch_line_t fetchReq = '0;
	misc_feature_pkg::fetch_line_t fetchLine;
	misc_feature_pkg::fetch_line_t fetchPair;
	int miscompares = 0;
	int nTests = 0;
	logic [31:0] rd;
	logic er;

	always #2 core_clk = ~core_clk;

	misc_feature_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .stopClockInputN(stopClockInputN), .fpErrorPinInN(fpErrorPinInN),
		.fpUnmaskedErr(fpUnmaskedErr), .fpErrorPinOutN(fpErrorPinOutN), .fpErrorPinOe(fpErrorPinOe),
		.wakeReq(wakeReq), .fetchReq(fetchReq), .fetchLine(fetchLine), .fetchPair(fetchPair));

	////////////////////////////////////////////////////////////////////////////////
	task stop_test();
		$display("mismatches %0d of %0d checks", miscompares, nTests);
		if (miscompares == 0 && nTests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	task chk(input logic [32:0] got, input logic [32:0] exp);
		nTests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// entered just after a rising edge; leaves one idle edge so the next call never collides
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task rdChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
		apb(a, 1'b0, 32'h0000_0000);
		chk({er, rd}, {expErr, exp});
	endtask : rdChk

	task fetchChk(input logic [31:0] a, input logic [32:0] expLine, input logic [32:0] expPair);
		fetchReq <= '{valid: 1'b1, addr: a};
		@(posedge core_clk);
		fetchReq <= '0;
		#1;
		chk(fetchLine, expLine);
		chk(fetchPair, expPair);
		@(posedge core_clk);
	endtask : fetchChk

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rdChk(`OFS_FEAT_LO, 32'h0000_0000, 1'b0);
		rdChk(`OFS_FEAT_HI, 32'h0000_0000, 1'b0);
		apb(`OFS_FEAT_LO, 1'b1, 32'hFFFF_FFFF);
		rdChk(`OFS_FEAT_LO, 32'h0008_0400, 1'b0);
		pstrb <= 4'h1;
		apb(`OFS_FEAT_LO, 1'b1, 32'h0000_0000);
		pstrb <= 4'hF;
		rdChk(`OFS_FEAT_LO, 32'h0008_0400, 1'b0);
		apb(`OFS_FEAT_HI, 1'b1, 32'hFFFF_FFFF);
		rdChk(`OFS_FEAT_HI, 32'h0000_0000, 1'b0);
		apb(12'h010, 1'b1, 32'h0000_0000);
		chk({31'h0, er}, 33'h1);
		rdChk(12'h010, 32'h0000_0000, 1'b1);
		rdChk(`OFS_FEAT_LO, 32'h0008_0400, 1'b0);
		fetchChk(32'h0000_1234, {1'b1, 32'h0000_1200}, {1'b0, 32'h0000_1240});
		apb(`OFS_FEAT_LO, 1'b1, 32'h0000_0400);
		fetchChk(32'h0000_1234, {1'b1, 32'h0000_1200}, {1'b1, 32'h0000_1240});
		fetchChk(32'h0000_12C4, {1'b1, 32'h0000_12C0}, {1'b1, 32'h0000_1280});
		// error flagging outside stop-clock, with the enable set and then clear
		fpUnmaskedErr <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk({fpErrorPinOe, fpErrorPinOutN}, 33'h2);
		rdChk(`OFS_IRQ_STATUS, 32'h0000_0002, 1'b0);
		chk({31'h0, irq}, 33'h0);
		fpUnmaskedErr <= 1'b0;
		apb(`OFS_FEAT_LO, 1'b1, 32'h0000_0000);
		fpUnmaskedErr <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk({fpErrorPinOe, fpErrorPinOutN}, 33'h2);
		fpUnmaskedErr <= 1'b0;
		repeat (2) @(posedge core_clk);
		apb(`OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
		rdChk(`OFS_IRQ_STATUS, 32'h0000_0000, 1'b0);
		// stop-clock wake: refused while the enable is clear
		stopClockInputN <= 1'b0;
		fpErrorPinInN <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk({fpErrorPinOe, wakeReq}, 33'h0);
		@(posedge core_clk);
		apb(`OFS_IRQ_MASK, 1'b1, 32'h0000_0001);
		apb(`OFS_FEAT_LO, 1'b1, 32'h0000_0400);
		repeat (3) @(posedge core_clk);
		#1;
		chk({31'h0, wakeReq}, 33'h1);
		chk({31'h0, irq}, 33'h1);
		@(posedge core_clk);
		rdChk(`OFS_IRQ_STATUS, 32'h0000_0001, 1'b0);
		fpErrorPinInN <= 1'b1;
		stopClockInputN <= 1'b1;
		repeat (2) @(posedge core_clk);
		apb(`OFS_IRQ_STATUS, 1'b1, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		#1;
		chk({irq, wakeReq}, 33'h0);
		@(posedge core_clk);
		stop_test();
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		stop_test();
	end
endmodule : misc_feature_ctrl_tb_top
